// ===== logic/dcs_sequencer.sv
`timescale 1ns/100ps
// Contract
// - A scan command of any variant takes nine bytes, opcode through sector step.
// - The seventh scan byte is kept as the last sector number of the track run.
// - A finished scan offers seven result bytes, status 0 to 2 then C, H, R, N.
// - Recalibrate takes opcode and unit select and has no result phase.
// - Interrupt status query answers status 0 then the present track number, or only an invalid status 0 when no event is pending.
// - Specify takes three bytes, stores the timing bytes and returns nothing.
// - Drive status query takes two bytes and answers one byte of drive signals.
// - Seek takes three bytes, stores the target track and returns nothing.
// - Bytes move only while the request flag is set; direction set means read.
// - Status 0 carries the end code in bits 7:6 and the seek end flag 0x20.
module dcs_sequencer
  import dcs_pkg::*;
(
  // Clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_rstn,
  // Host data port
  input  wire logic          i_wr_stb,
  input  wire logic [7:0]    i_wr_data,
  input  wire logic          i_rd_stb,
  output logic      [7:0]    o_rd_data,
  output logic      [7:0]    o_main_status,
  // Scan execution
  output logic               o_scan_start,
  output dcs_scan_req_t      o_scan_req,
  input  wire logic          i_exec_done,
  input  wire logic          i_exec_abnormal,
  input  wire logic [7:0]    i_exec_st1,
  input  wire logic [7:0]    i_exec_st2,
  // Drive pins and settings
  input  wire logic [7:0]    i_drive_sig,
  output logic      [7:0]    o_step_rate_unload_time,
  output logic      [7:0]    o_head_load_nondma_select,
  output logic      [7:0]    o_present_track_number
);
  // ==========================================================
  // State
  dcs_state_t       state_q, state_d;
  logic [8:0][7:0]  cmd_q, cmd_d;
  logic [6:0][7:0]  res_q, res_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [3:0]       len_q, len_d;
  logic [2:0]       res_cnt_q, res_cnt_d;
  logic [7:0]       trk_q, trk_d;
  logic             pend_q, pend_d;
  logic [2:0]       pend_unit_q, pend_unit_d;
  logic [7:0]       rate_q, rate_d;
  logic [7:0]       load_q, load_d;
  logic             start_q, start_d;
  logic [7:0]       drv_meta_q, drv_q;
  logic             master_request_flag;
  logic             transfer_direction_flag;
  logic             wr_ok;
  logic             rd_ok;
  logic [7:0]       st0;

  // ==========================================================
  // Host handshake
  // request and direction
  assign master_request_flag     = (state_q != ST_EXEC);
  assign transfer_direction_flag = (state_q == ST_RES);
  assign wr_ok = i_wr_stb && master_request_flag && !transfer_direction_flag;
  assign rd_ok = i_rd_stb && transfer_direction_flag;
  always_comb begin
    o_main_status                = BYTE_ZERO;
    o_main_status[MSR_REQ_BIT]   = master_request_flag;
    o_main_status[MSR_DIR_BIT]   = transfer_direction_flag;
    o_main_status[MSR_BUSY_BIT]  = (state_q != ST_IDLE);
  end

  // ==========================================================
  // Command length lookup
  function automatic logic [3:0] cmd_len(input logic [4:0] op);
    case (op)
      OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE: cmd_len = LEN_SCAN;
      OP_RECAL:                           cmd_len = LEN_RECAL;
      OP_SENSE_INT:                       cmd_len = LEN_SENSE_INT;
      OP_SPECIFY:                         cmd_len = LEN_SPECIFY;
      OP_SENSE_DRV:                       cmd_len = LEN_SENSE_DRV;
      OP_SEEK:                            cmd_len = LEN_SEEK;
      default:                            cmd_len = LEN_NONE;
    endcase
  endfunction

  // ==========================================================
  // Sequencer next state
  always_comb begin
    state_d     = state_q;
    cmd_d       = cmd_q;
    res_d       = res_q;
    cnt_d       = cnt_q;
    len_d       = len_q;
    res_cnt_d   = res_cnt_q;
    trk_d       = trk_q;
    pend_d      = pend_q;
    pend_unit_d = pend_unit_q;
    rate_d      = rate_q;
    load_d      = load_q;
    start_d     = 1'b0;
    st0         = BYTE_ZERO;
    case (state_q)
      ST_IDLE: begin
        if (wr_ok) begin
          cmd_d[0] = i_wr_data;
          len_d    = cmd_len(i_wr_data[4:0]);
          cnt_d    = 4'h1;
          if (cmd_len(i_wr_data[4:0]) == LEN_NONE) begin
            res_d[0]  = ST0_IC_INV;
            res_cnt_d = RES_ONE;
            state_d   = ST_RES;
          end else begin
            state_d = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        if (wr_ok) begin
          cmd_d[cnt_q] = i_wr_data;
          cnt_d        = cnt_q + 4'h1;
          if (cnt_d == len_q) begin
            // no result phase returns to idle
            state_d = ST_IDLE;
            case (cmd_q[0][4:0])
              OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE: begin
                start_d = 1'b1;
                state_d = ST_EXEC;
              end
              OP_RECAL: begin
                trk_d       = BYTE_ZERO;
                pend_d      = 1'b1;
                pend_unit_d = cmd_d[IDX_UNIT][2:0];
              end
              OP_SEEK: begin
                trk_d       = cmd_d[IDX_CYL];
                pend_d      = 1'b1;
                pend_unit_d = cmd_d[IDX_UNIT][2:0];
              end
              OP_SPECIFY: begin
                rate_d = cmd_d[1];
                load_d = cmd_d[2];
              end
              OP_SENSE_INT: begin
                state_d = ST_RES;
                if (pend_q) begin
                  res_d[0]  = ST0_IC_NORM | ST0_SEEK_END | {5'h00, pend_unit_q};
                  res_d[1]  = trk_q;
                  res_cnt_d = RES_SENSE_INT;
                  pend_d    = 1'b0;
                end else begin
                  res_d[0]  = ST0_IC_INV;
                  res_cnt_d = RES_ONE;
                end
              end
              default: begin
                res_d[0]  = {drv_q[7:3], cmd_d[IDX_UNIT][2:0]};
                res_cnt_d = RES_ONE;
                state_d   = ST_RES;
              end
            endcase
          end
        end
      end
      ST_EXEC: begin
        if (i_exec_done) begin
          st0 = !drv_q[ST3_RDY_BIT] ? ST0_IC_NRDY : (i_exec_abnormal ? ST0_IC_ABN : ST0_IC_NORM);
          res_d[0]  = st0 | {5'h00, cmd_q[IDX_UNIT][2:0]};
          res_d[1]  = i_exec_st1;
          res_d[2]  = i_exec_st2;
          res_d[3]  = cmd_q[IDX_CYL];
          res_d[4]  = cmd_q[IDX_HEAD];
          res_d[5]  = cmd_q[IDX_SECT];
          res_d[6]  = cmd_q[IDX_SIZE];
          res_cnt_d = RES_SCAN;
          state_d   = ST_RES;
        end
      end
      ST_RES: begin
        if (rd_ok) begin
          res_d     = {BYTE_ZERO, res_q[6:1]};
          res_cnt_d = res_cnt_q - 3'h1;
          if (res_cnt_q == RES_ONE) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q     <= ST_IDLE;
      cmd_q       <= '0;
      res_q       <= '0;
      cnt_q       <= 4'h0;
      len_q       <= 4'h0;
      res_cnt_q   <= 3'h0;
      trk_q       <= BYTE_ZERO;
      pend_q      <= 1'b0;
      pend_unit_q <= 3'h0;
      rate_q      <= BYTE_ZERO;
      load_q      <= BYTE_ZERO;
      start_q     <= 1'b0;
      drv_meta_q  <= BYTE_ZERO;
      drv_q       <= BYTE_ZERO;
    end else begin
      state_q     <= state_d;
      cmd_q       <= cmd_d;
      res_q       <= res_d;
      cnt_q       <= cnt_d;
      len_q       <= len_d;
      res_cnt_q   <= res_cnt_d;
      trk_q       <= trk_d;
      pend_q      <= pend_d;
      pend_unit_q <= pend_unit_d;
      rate_q      <= rate_d;
      load_q      <= load_d;
      start_q     <= start_d;
      drv_meta_q  <= i_drive_sig;
      drv_q       <= drv_meta_q;
    end
  end

  // ==========================================================
  // Outputs
  assign o_rd_data                 = res_q[0];
  assign o_scan_start              = start_q;
  assign o_step_rate_unload_time   = rate_q;
  assign o_head_load_nondma_select = load_q;
  assign o_present_track_number    = trk_q;
  assign o_scan_req = '{opcode: cmd_q[0][4:0], unit_select: cmd_q[IDX_UNIT],
                        cylinder: cmd_q[IDX_CYL], head: cmd_q[IDX_HEAD],
                        sector: cmd_q[IDX_SECT], size_code: cmd_q[IDX_SIZE],
                        end_sector_number: cmd_q[IDX_END],
                        gap_length_byte: cmd_q[IDX_GAP],
                        scan_sector_step: cmd_q[IDX_STEP]};

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  logic [7:0] end_seen_q;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      end_seen_q <= BYTE_ZERO;
    end else if (state_q == ST_CMD && wr_ok && cnt_q == 4'(IDX_END)) begin
      end_seen_q <= i_wr_data;
    end
  end
  sequence s_last_wr(logic [4:0] op);
    state_q == ST_CMD && wr_ok && cmd_q[0][4:0] == op && cnt_q + 4'h1 == len_q;
  endsequence
  a_req_dir_read: assert property ((state_q == ST_RES) |->
    o_main_status[MSR_REQ_BIT] && o_main_status[MSR_DIR_BIT]) else $error("read phase flags");
  a_exec_no_req: assert property ((state_q == ST_EXEC) |->
    !o_main_status[MSR_REQ_BIT]) else $error("request during execution");
  a_scan_nine: assert property (o_scan_start |->
    $past(cnt_q) == LEN_SCAN - 4'h1 && o_scan_req.scan_sector_step == $past(i_wr_data))
    else $error("scan byte count wrong");
  a_end_sector: assert property (o_scan_start |->
    o_scan_req.end_sector_number == end_seen_q) else $error("end sector wrong");
  a_scan_results: assert property ((state_q == ST_EXEC && i_exec_done) |=>
    state_q == ST_RES && res_cnt_q == RES_SCAN) else $error("scan results wrong");
  a_recal_none: assert property (s_last_wr(OP_RECAL) |=>
    state_q == ST_IDLE && o_present_track_number == BYTE_ZERO) else $error("recal wrong");
  a_sense_int_two: assert property ((s_last_wr(OP_SENSE_INT) ##0 pend_q) |=>
    res_cnt_q == RES_SENSE_INT && (o_rd_data & ST0_SEEK_END) == ST0_SEEK_END &&
    o_rd_data[2:0] == $past(pend_unit_q) && res_q[1] == trk_q) else $error("interrupt status wrong");
  a_specify_store: assert property (s_last_wr(OP_SPECIFY) |=>
    state_q == ST_IDLE && o_head_load_nondma_select == $past(i_wr_data))
    else $error("specify wrong");
  a_drive_one: assert property (s_last_wr(OP_SENSE_DRV) |=>
    state_q == ST_RES && res_cnt_q == RES_ONE) else $error("drive status wrong");
  a_seek_track: assert property (s_last_wr(OP_SEEK) |=>
    state_q == ST_IDLE && pend_q && o_present_track_number == $past(i_wr_data))
    else $error("seek wrong");
  a_invalid_code: assert property ((state_q == ST_IDLE && wr_ok &&
    cmd_len(i_wr_data[4:0]) == LEN_NONE) |=> o_rd_data[7:6] == ST0_IC_INV[7:6])
    else $error("invalid code wrong");
  a_idle_after_last: assert property ((rd_ok && res_cnt_q == RES_ONE) |=>
    state_q == ST_IDLE) else $error("not idle after last result");
endmodule // dcs_sequencer

// ===== include/dcs_pkg.sv
package dcs_pkg;
  // ==========================================================
  // Opcodes, low five bits of the first command byte
  localparam logic [4:0] OP_SCAN_EQ   = 5'h11;
  localparam logic [4:0] OP_SCAN_LE   = 5'h19;
  localparam logic [4:0] OP_SCAN_HE   = 5'h1d;
  localparam logic [4:0] OP_RECAL     = 5'h07;
  localparam logic [4:0] OP_SENSE_INT = 5'h08;
  localparam logic [4:0] OP_SPECIFY   = 5'h03;
  localparam logic [4:0] OP_SENSE_DRV = 5'h04;
  localparam logic [4:0] OP_SEEK      = 5'h0f;
  // ==========================================================
  // Command and result lengths
  localparam logic [3:0] LEN_NONE      = 4'h0;
  localparam logic [3:0] LEN_SCAN      = 4'h9;
  localparam logic [3:0] LEN_RECAL     = 4'h2;
  localparam logic [3:0] LEN_SENSE_INT = 4'h2;
  localparam logic [3:0] LEN_SPECIFY   = 4'h3;
  localparam logic [3:0] LEN_SENSE_DRV = 4'h2;
  localparam logic [3:0] LEN_SEEK      = 4'h3;
  localparam logic [2:0] RES_SCAN      = 3'h7;
  localparam logic [2:0] RES_SENSE_INT = 3'h2;
  localparam logic [2:0] RES_ONE       = 3'h1;
  // ==========================================================
  // Command byte positions
  localparam int IDX_UNIT = 1;
  localparam int IDX_CYL  = 2;
  localparam int IDX_HEAD = 3;
  localparam int IDX_SECT = 4;
  localparam int IDX_SIZE = 5;
  localparam int IDX_END  = 6;
  localparam int IDX_GAP  = 7;
  localparam int IDX_STEP = 8;
  // ==========================================================
  // Status bits and codes
  localparam int         MSR_REQ_BIT  = 7;
  localparam int         MSR_DIR_BIT  = 6;
  localparam int         MSR_BUSY_BIT = 4;
  localparam int         ST3_RDY_BIT  = 5;
  localparam logic [7:0] ST0_IC_NORM  = 8'h00;
  localparam logic [7:0] ST0_IC_ABN   = 8'h40;
  localparam logic [7:0] ST0_IC_INV   = 8'h80;
  localparam logic [7:0] ST0_IC_NRDY  = 8'hc0;
  localparam logic [7:0] ST0_SEEK_END = 8'h20;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  // ==========================================================
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_EXEC = 2'b10,
    ST_RES  = 2'b11
  } dcs_state_t;

  typedef struct packed {
    logic [4:0] opcode;
    logic [7:0] unit_select;
    logic [7:0] cylinder;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size_code;
    logic [7:0] end_sector_number;
    logic [7:0] gap_length_byte;
    logic [7:0] scan_sector_step;
  } dcs_scan_req_t;
endpackage

// ===== testbench/dcs_exec_model.sv
`timescale 1ns/100ps
// ==========================================================
// Scan executor stand-in, answers each start after a delay
module dcs_exec_model (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  // Control
  input  wire logic       i_start,
  input  wire logic [3:0] i_dly,
  // Result
  output logic            o_done
);
  logic [3:0] cnt_q;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q  <= 4'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt_q == 4'h1);
      if (i_start) cnt_q <= i_dly;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // dcs_exec_model

// ===== testbench/dcs_sequencer_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module dcs_sequencer_tb_top;
  import dcs_pkg::*;
  logic          i_mclk, i_rstn, i_wr_stb, i_rd_stb, i_exec_abnormal, o_scan_start, done;
  logic [7:0]    i_wr_data, o_rd_data, o_main_status, i_exec_st1, i_exec_st2, i_drive_sig;
  logic [7:0]    o_rate, o_load, o_trk;
  dcs_scan_req_t o_scan_req, req_seen;
  int            n_mismatch, cmp_count, n_start;
  logic [7:0]    sb [9];
  logic [7:0]    st0;
  // ==========================================================
  dcs_sequencer dcs_sequencer_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_wr_stb(i_wr_stb),
    .i_wr_data(i_wr_data), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
    .o_main_status(o_main_status), .o_scan_start(o_scan_start), .o_scan_req(o_scan_req),
    .i_exec_done(done), .i_exec_abnormal(i_exec_abnormal), .i_exec_st1(i_exec_st1),
    .i_exec_st2(i_exec_st2), .i_drive_sig(i_drive_sig), .o_step_rate_unload_time(o_rate),
    .o_head_load_nondma_select(o_load), .o_present_track_number(o_trk));
  dcs_exec_model dcs_exec_model_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(o_scan_start),
    .i_dly(4'h5), .o_done(done));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Start pulse monitor
  always @(negedge i_mclk) begin
    if (o_scan_start === 1'b1) begin
      n_start++;
      req_seen = o_scan_req;
    end
  end
  // ==========================================================
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr_raw(input logic [7:0] d);
    @(posedge i_mclk);
    i_wr_stb  <= 1'b1;
    i_wr_data <= d;
    @(posedge i_mclk);
    i_wr_stb  <= 1'b0;
  endtask
  // write only on request, direction clear
  task automatic wr_byte(input logic [7:0] d);
    int k;
    for (k = 0; k < 50; k++) begin
      @(negedge i_mclk);
      if (o_main_status[7] === 1'b1 && o_main_status[6] === 1'b0) break;
    end
    if (k == 50) `CHK(o_main_status, 8'h80)
    wr_raw(d);
  endtask
  task automatic rd_byte(input logic [7:0] e);
    int k;
    for (k = 0; k < 50; k++) begin
      @(negedge i_mclk);
      if (o_main_status === 8'hd0) break;
    end
    `CHK(o_main_status, 8'hd0)
    `CHK(o_rd_data, e)
    @(posedge i_mclk);
    i_rd_stb <= 1'b1;
    @(posedge i_mclk);
    i_rd_stb <= 1'b0;
  endtask
  task automatic chk_idle();
    @(negedge i_mclk);
    `CHK(o_main_status, 8'h80)
  endtask
  // ==========================================================
  initial begin
    {i_rstn, i_wr_stb, i_rd_stb, i_exec_abnormal} = 4'h0;
    {i_wr_data, i_exec_st1, i_exec_st2} = 24'h00_0000;
    i_drive_sig = 8'ha8;
    n_mismatch = 0;
    cmp_count = 0;
    n_start = 0;
    repeat (6) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(negedge i_mclk);
    `CHK(o_main_status, 8'h80)
    `CHK(o_rd_data, 8'h00)
    // Specify then idle at once
    wr_byte(8'h03);
    wr_byte(8'ha5);
    wr_byte(8'h5a);
    chk_idle();
    `CHK({o_rate, o_load}, 16'ha55a)
    // Interrupt query without pending event
    wr_byte(8'h08);
    wr_byte(8'h00);
    rd_byte(ST0_IC_INV);
    chk_idle();
    // Seek then interrupt query
    wr_byte(8'h0f);
    wr_byte(8'h01);
    wr_byte(8'h23);
    chk_idle();
    `CHK(o_trk, 8'h23)
    wr_byte(8'h08);
    wr_byte(8'h01);
    rd_byte(8'h21);
    rd_byte(8'h23);
    chk_idle();
    // Recalibrate then interrupt query
    wr_byte(8'h07);
    wr_byte(8'h02);
    chk_idle();
    `CHK(o_trk, 8'h00)
    wr_byte(8'h08);
    wr_byte(8'h02);
    rd_byte(8'h22);
    rd_byte(8'h00);
    chk_idle();
    // Drive status query
    wr_byte(8'h04);
    wr_byte(8'h03);
    rd_byte(8'hab);
    chk_idle();
    // Three scan variants, three end codes
    for (int i = 0; i < 3; i++) begin
      sb = '{8'h00, 8'h01, 8'h10, 8'h00, 8'h03, 8'h02, 8'h12, 8'h1b, 8'h01};
      sb[0] = (i == 0) ? 8'h11 : (i == 1) ? 8'h19 : 8'h1d;
      st0 = (i == 0) ? 8'h01 : (i == 1) ? 8'h41 : 8'hc1;
      @(posedge i_mclk);
      i_exec_abnormal <= (i != 0);
      i_exec_st1 <= 8'(8'h80 + i);
      i_exec_st2 <= 8'(8'h04 + i);
      i_drive_sig <= (i == 2) ? 8'h88 : 8'ha8;
      for (int j = 0; j < 9; j++) wr_byte(sb[j]);
      repeat (2) @(negedge i_mclk);
      `CHK(o_main_status, 8'h10)
      `CHK(n_start, i + 1)
      `CHK(req_seen, {sb[0][4:0], sb[1], sb[2], sb[3], sb[4], sb[5], sb[6], sb[7], sb[8]})
      `CHK(req_seen.end_sector_number, 8'h12)
      rd_byte(st0);
      rd_byte(8'(8'h80 + i));
      rd_byte(8'(8'h04 + i));
      for (int j = 2; j < 6; j++) rd_byte(sb[j]);
      chk_idle();
    end
    // Unknown opcode, write in result phase ignored
    wr_byte(8'h1f);
    wr_raw(8'h0f);
    rd_byte(ST0_IC_INV);
    chk_idle();
    `CHK(o_trk, 8'h00)
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge i_mclk);
    n_mismatch++;
    print_verdict();
  end
endmodule // dcs_sequencer_tb_top
